// File: rtl/modem_rate_format_config.sv
`timescale 1ns/10ps
// What this block does
// - Carrier word low byte register, resets 0xec.
// - Four-bit rate exponent, bits 3:0, reset twelve.
// - Eight-bit rate mantissa register, resets 0x22.
// - Mantissa gets implied ninth one bit.
// - Symbol rate is clock*(256+M)*2^E/2^28.
// - Decode modulation select bits 6:4, reset 000.
// - Bit 3 enables Manchester coding, reset zero.
module modem_rate_format_config (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [5:0]                   reg_addr,
    input  wire logic                         reg_wr_en,
    input  wire logic [7:0]                   reg_wr_data,
    output logic      [7:0]                   reg_rd_data,
    output logic                              reg_rd_hit,
    input  wire logic                         tx_data_in,
    output logic                              tx_bit_take,
    output logic                              symbol_tick,
    output logic                              tx_chip_out,
    output modem_cfg_pkg::modem_cfg_type      modem_cfg
);
    import modem_cfg_pkg::*;

    localparam int ACC_W = RATE_DIVISOR_LOG2;   // Accumulator width sets the divisor.

    logic [7:0]       carrier_word_a_low_q;               // Carrier word low byte.
    logic [7:0]       rate_exp_q;               // Exponent register, upper nibble opaque.
    logic [7:0]       rate_mant_q;              // Mantissa register.
    logic [7:0]       mod_fmt_q;                // Modem control byte.
    logic [ACC_W-1:0] rate_acc_q;               // Phase accumulator of the rate generator.
    logic [ACC_W:0]   rate_sum;                 // Accumulator sum including carry.
    logic [ACC_W-1:0] rate_step;                // Per-clock increment.
    logic [ACC_W-1:0] rate_base;                // Mantissa with its hidden one, widened.
    logic             chip_phase_q;             // Second half of a Manchester bit.
    logic             data_bit_q;               // Bit being sent.
    logic             tx_chip_q;                // Registered line chip.

    // Write strobe decode, shared by every register process.
    function automatic logic wr_hit(input logic [5:0] ofs);
        wr_hit = reg_wr_en && (reg_addr == ofs);
    endfunction : wr_hit

    // Carrier low byte keeps its value until the host rewrites it.
    always_ff @(posedge clk) begin
        if (rst) begin
            carrier_word_a_low_q <= CARRIER_CARRIER_WORD_A_LOW_RST;
        end else if (wr_hit(CARRIER_CARRIER_WORD_A_LOW_BYTE_OFS)) begin
            carrier_word_a_low_q <= reg_wr_data;
        end
    end

    // Exponent register; the upper nibble is stored untouched for the host.
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_exp_q <= SYMBOL_RATE_EXP_RST;
        end else if (wr_hit(SYMBOL_RATE_EXPONENT_CFG_OFS)) begin
            rate_exp_q <= reg_wr_data;
        end
    end

    // Mantissa register occupies the whole byte.
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_mant_q <= SYMBOL_RATE_MANT_RST;
        end else if (wr_hit(SYMBOL_RATE_MANTISSA_CFG_OFS)) begin
            rate_mant_q <= reg_wr_data;
        end
    end

    // Modem control byte: format, Manchester enable and sync mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            mod_fmt_q <= MODULATION_FORMAT_RST;
        end else if (wr_hit(MODULATION_FORMAT_CFG_OFS)) begin
            // Bit 7 is kept as written; only the read mux returns it.
            mod_fmt_q <= reg_wr_data;
        end
    end

    // Read mux is combinational so the serial port can shift the byte out at once.
    always_comb begin
        reg_rd_hit  = 1'b1;
        case (reg_addr)
            CARRIER_CARRIER_WORD_A_LOW_BYTE_OFS:    reg_rd_data = carrier_word_a_low_q;
            SYMBOL_RATE_EXPONENT_CFG_OFS: reg_rd_data = rate_exp_q;
            SYMBOL_RATE_MANTISSA_CFG_OFS: reg_rd_data = rate_mant_q;
            MODULATION_FORMAT_CFG_OFS:    reg_rd_data = mod_fmt_q;
            default: begin
                // Addresses outside this bank read zero and report a miss.
                reg_rd_data = 8'h00;
                reg_rd_hit  = 1'b0;
            end
        endcase
    end

    // Widen the nine-bit mantissa before shifting, so a narrow shift cannot drop top bits.
    assign rate_base = ACC_W'(RATE_MANTISSA_HIDDEN | {1'b0, rate_mant_q});
    // Step is the mantissa shifted by the exponent; at most 511 << 15 fits.
    assign rate_step = rate_base << rate_exp_q[RATE_EXPONENT_MSB:RATE_EXPONENT_LSB];
    // The extra top bit of the sum keeps the carry that becomes the tick.
    assign rate_sum  = {1'b0, rate_acc_q} + {1'b0, rate_step};

    // The accumulator wraps at 2^28, so its carry rate is the documented symbol rate.
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_acc_q <= '0;
        end else begin
            rate_acc_q <= rate_sum[ACC_W-1:0];
        end
    end

    // A carry out of the accumulator marks one symbol period.
    assign symbol_tick = rate_sum[ACC_W];

    // New data is taken at the start of each bit; with Manchester a bit spans two chips.
    assign tx_bit_take = symbol_tick && !(mod_fmt_q[MANCHESTER_EN_BIT] && chip_phase_q);

    // Chip phase only advances while Manchester coding is on.
    always_ff @(posedge clk) begin
        if (rst) begin
            chip_phase_q <= 1'b0;
        end else if (!mod_fmt_q[MANCHESTER_EN_BIT]) begin
            chip_phase_q <= 1'b0;
        end else if (symbol_tick) begin
            chip_phase_q <= !chip_phase_q;
        end
    end

    // Hold the taken bit for the whole coded period.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_bit_q <= 1'b0;
        end else if (tx_bit_take) begin
            data_bit_q <= tx_data_in;
        end
    end

    // Line chip: the bit itself, or bit then its inverse when Manchester is on.
    // Manchester with four-level FSK is left to the host to avoid; no check here.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_chip_q <= 1'b0;
        end else if (symbol_tick) begin
            if (mod_fmt_q[MANCHESTER_EN_BIT]) begin
                tx_chip_q <= chip_phase_q ? !data_bit_q : tx_data_in;
            end else begin
                tx_chip_q <= tx_data_in;
            end
        end
    end

    // The line chip leaves straight from its flip-flop, so it never glitches.
    assign tx_chip_out = tx_chip_q;

    // Decode the control byte for the modulator.
    always_comb begin
        modem_cfg                   = '0;
        modem_cfg.carrier_word_a    = carrier_word_a_low_q;
        modem_cfg.modulation_select = modulation_select_type'(
            mod_fmt_q[MODULATION_SELECT_MSB:MODULATION_SELECT_LSB]);
        modem_cfg.manchester_en     = mod_fmt_q[MANCHESTER_EN_BIT];
        // Reserved formats are flagged so the modulator can hold off on them.
        case (modem_cfg.modulation_select)
            MOD_FSK2, MOD_GFSK, MOD_OOK, MOD_FSK4: modem_cfg.mod_reserved = 1'b0;
            default:                               modem_cfg.mod_reserved = 1'b1;
        endcase
        case (sync_mode_type'(mod_fmt_q[SYNC_MODE_MSB:SYNC_MODE_LSB]))
            SYNC_NONE: modem_cfg.sync_bits_div8 = 6'h00;
            SYNC_16:   modem_cfg.sync_bits_div8 = 6'h02;
            SYNC_32:   modem_cfg.sync_bits_div8 = 6'h04;
            default: begin
                // Reserved codes send nothing and raise the flag.
                modem_cfg.sync_bits_div8 = 6'h00;
                modem_cfg.sync_reserved  = 1'b1;
            end
        endcase
    end

    // Checks on the register bank and the rate generator.
    // The carrier byte must come out of reset at its default.
    AST_CARRIER_WORD_A_RESET: assert property (@(posedge clk)
        rst |=> carrier_word_a_low_q == CARRIER_CARRIER_WORD_A_LOW_RST)
        else $error("carrier low byte reset value wrong");
    // A write to the carrier byte must land in the register, whatever the address does next.
    AST_CARRIER_WORD_A_WRITE: assert property (@(posedge clk) disable iff (rst)
        reg_wr_en && reg_addr == CARRIER_CARRIER_WORD_A_LOW_BYTE_OFS
        |=> carrier_word_a_low_q == $past(reg_wr_data))
        else $error("carrier low byte write lost");
    // Only the exponent nibble has a fixed meaning; the upper nibble is checked by reads.
    AST_EXP_RESET: assert property (@(posedge clk)
        rst |=> rate_exp_q[RATE_EXPONENT_MSB:RATE_EXPONENT_LSB] == SYMBOL_RATE_EXP_RST[3:0])
        else $error("exponent reset value wrong");
    // The mantissa register resets as a whole byte.
    AST_MANT_RESET: assert property (@(posedge clk)
        rst |=> rate_mant_q == SYMBOL_RATE_MANT_RST)
        else $error("mantissa reset value wrong");
    // The step must carry the hidden ninth bit, worked out here in a separate form.
    AST_STEP_VALUE: assert property (@(posedge clk) disable iff (rst)
        rate_step == ((28'd256 + 28'(rate_mant_q)) << rate_exp_q[3:0]))
        else $error("rate step does not use hidden one");
    // A tick is only raised when the accumulator wraps past its top.
    AST_TICK_CARRY: assert property (@(posedge clk) disable iff (rst)
        symbol_tick |=> rate_acc_q < $past(rate_acc_q))
        else $error("symbol tick without accumulator wrap");
    // After reset the control byte decodes to two-level FSK, no coding, reserved sync.
    AST_MOD_RESET: assert property (@(posedge clk)
        rst |=> modem_cfg.modulation_select == MOD_FSK2 && !modem_cfg.manchester_en
        && modem_cfg.sync_reserved)
        else $error("modem control byte reset wrong");
    // The second chip of a coded bit is the inverse of the held bit.
    AST_MANCH_SECOND: assert property (@(posedge clk) disable iff (rst)
        symbol_tick && chip_phase_q && mod_fmt_q[MANCHESTER_EN_BIT]
        |=> tx_chip_q == !data_bit_q)
        else $error("second Manchester chip not inverted");
    // With coding off every tick puts the data bit itself on the line.
    AST_PLAIN_CHIP: assert property (@(posedge clk) disable iff (rst)
        symbol_tick && !mod_fmt_q[MANCHESTER_EN_BIT] |=> tx_chip_q == $past(tx_data_in))
        else $error("uncoded chip differs from data");
    // The 32-bit sync code must ask for four sync bytes.
    AST_SYNC_32: assert property (@(posedge clk) disable iff (rst)
        mod_fmt_q[SYNC_MODE_MSB:SYNC_MODE_LSB] == SYNC_32 |-> modem_cfg.sync_bits_div8 == 6'h04)
        else $error("32-bit sync mode decoded wrong");

endmodule : modem_rate_format_config

// File: rtl/modem_cfg_pkg.sv
package modem_cfg_pkg;

    // Register offsets on the serial register port.
    localparam logic [5:0] CARRIER_CARRIER_WORD_A_LOW_BYTE_OFS    = 6'h0f;
    localparam logic [5:0] SYMBOL_RATE_EXPONENT_CFG_OFS = 6'h10;
    localparam logic [5:0] SYMBOL_RATE_MANTISSA_CFG_OFS = 6'h11;
    localparam logic [5:0] MODULATION_FORMAT_CFG_OFS    = 6'h12;

    // Reset values of the whole registers.
    localparam logic [7:0] CARRIER_CARRIER_WORD_A_LOW_RST    = 8'hec;
    localparam logic [7:0] SYMBOL_RATE_EXP_RST     = 8'h8c;
    localparam logic [7:0] SYMBOL_RATE_MANT_RST    = 8'h22;
    localparam logic [7:0] MODULATION_FORMAT_RST   = 8'h02;

    // Field positions.
    localparam int RATE_EXPONENT_LSB     = 0;
    localparam int RATE_EXPONENT_MSB     = 3;
    localparam int MODULATION_SELECT_LSB = 4;
    localparam int MODULATION_SELECT_MSB = 6;
    localparam int MANCHESTER_EN_BIT     = 3;
    localparam int SYNC_MODE_LSB         = 0;
    localparam int SYNC_MODE_MSB         = 2;

    // Rate generator constants: implied mantissa one and the fixed divisor.
    localparam logic [8:0] RATE_MANTISSA_HIDDEN = 9'h100;
    localparam int         RATE_DIVISOR_LOG2    = 28;

    // Modulation formats.
    typedef enum logic [2:0] {
        MOD_FSK2     = 3'b000,
        MOD_GFSK     = 3'b001,
        MOD_RSVD_2   = 3'b010,
        MOD_OOK      = 3'b011,
        MOD_FSK4     = 3'b100,
        MOD_RSVD_5   = 3'b101,
        MOD_RSVD_6   = 3'b110,
        MOD_RSVD_7   = 3'b111
    } modulation_select_type;

    // Sync word modes.
    typedef enum logic [2:0] {
        SYNC_NONE    = 3'b000,
        SYNC_16      = 3'b001,
        SYNC_RSVD_2  = 3'b010,
        SYNC_32      = 3'b011,
        SYNC_RSVD_4  = 3'b100,
        SYNC_RSVD_5  = 3'b101,
        SYNC_RSVD_6  = 3'b110,
        SYNC_RSVD_7  = 3'b111
    } sync_mode_type;

    // Decoded configuration handed to the modulator.
    typedef struct packed {
        logic [7:0]            carrier_word_a;   // Low byte of the carrier word.
        modulation_select_type modulation_select;
        logic                  mod_reserved;     // Reserved format code selected.
        logic                  manchester_en;
        logic [5:0]            sync_bits_div8;   // Sync length in bytes: 0, 2 or 4.
        logic                  sync_reserved;    // Reserved sync code selected.
    } modem_cfg_type;

endpackage : modem_cfg_pkg

// File: tb/host_model.sv
`timescale 1ns/10ps
// Host side of the register port and the serial data source.
module host_model (
    input  wire logic       clk,
    input  wire logic       tx_bit_take,
    output logic      [5:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            tx_data_in
);
    logic [15:0] pattern_q = 16'hb38d; // Uneven pattern so stuck chips show up.

    initial begin
        reg_addr    = 6'h3f;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
    end

    assign tx_data_in = pattern_q[15];

    // The next data bit is presented only after the block has taken the current one.
    always @(posedge clk) begin
        if (tx_bit_take === 1'b1) begin
            pattern_q <= {pattern_q[14:0], pattern_q[15]};
        end
    end

    // One write is a single strobe cycle, then the strobe drops for an edge.
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 6'h12 && v[6:4] == 3'b100) begin
            v[3] = 1'b0;
        end
        @(posedge clk);
        reg_addr    <= a;
        reg_wr_data <= v;
        reg_wr_en   <= 1'b1;
        @(posedge clk);
        reg_wr_en   <= 1'b0;
        reg_wr_data <= ~v; // Data no longer qualified, so it shows a changed value.
    endtask : write_reg

    // Reads are combinational, so the address is set and the bus sampled mid-cycle.
    task automatic set_addr(input logic [5:0] a);
        @(posedge clk);
        reg_addr <= a;
        @(negedge clk);
    endtask : set_addr
endmodule : host_model

// File: tb/modem_rate_format_config_test.sv
`timescale 1ns/10ps
module modem_rate_format_config_test;
    import modem_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] reg_addr;
    logic reg_wr_en, tx_data_in, tx_bit_take, symbol_tick, tx_chip_out, reg_rd_hit;
    logic [7:0] reg_wr_data, reg_rd_data;
    modem_cfg_type modem_cfg;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    modem_rate_format_config modem_rate_format_config_i (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit), .tx_data_in(tx_data_in),
        .tx_bit_take(tx_bit_take), .symbol_tick(symbol_tick), .tx_chip_out(tx_chip_out),
        .modem_cfg(modem_cfg));
    host_model host_model_i (.clk(clk), .tx_bit_take(tx_bit_take), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .tx_data_in(tx_data_in));

    // Each comparison is counted; a failed one is reported at once.
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Reads one register and compares value and hit flag.
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input logic h);
        host_model_i.set_addr(a);
        chk(reg_rd_data === e && reg_rd_hit === h, "register read");
    endtask : rd_chk

    // Reset contents, then back-to-back writes and an ignored unmapped write.
    task automatic reset_and_rw();
        rd_chk(6'h0f, 8'hec, 1'b1);
        rd_chk(6'h10, 8'h8c, 1'b1);
        rd_chk(6'h11, 8'h22, 1'b1);
        rd_chk(6'h12, 8'h02, 1'b1);
        chk(modem_cfg.manchester_en === 1'b0 && modem_cfg.sync_reserved === 1'b1, "reset");
        host_model_i.write_reg(6'h0f, 8'h5a);
        host_model_i.write_reg(6'h10, 8'h73);
        host_model_i.write_reg(6'h11, 8'ha6);
        host_model_i.write_reg(6'h13, 8'hff);
        rd_chk(6'h0f, 8'h5a, 1'b1);
        chk(modem_cfg.carrier_word_a === 8'h5a, "carrier byte");
        rd_chk(6'h10, 8'h73, 1'b1);
        rd_chk(6'h11, 8'ha6, 1'b1);
        rd_chk(6'h13, 8'h00, 1'b0);
    endtask : reset_and_rw

    // Every format and sync code, with the expected decode worked out here.
    task automatic code_sweep();
        logic [5:0] b;
        for (int i = 0; i < 8; i++) begin
            host_model_i.write_reg(6'h12, {1'b0, i[2:0], 1'b0, i[2:0]});
            host_model_i.set_addr(6'h12);
            b = (i == 1) ? 6'd2 : (i == 3) ? 6'd4 : 6'd0;
            chk(modem_cfg.modulation_select === i[2:0], "format");
            chk(modem_cfg.mod_reserved === !(i inside {0, 1, 3, 4}), "format flag");
            chk(modem_cfg.sync_bits_div8 === b, "sync length");
            chk(modem_cfg.sync_reserved === !(i inside {0, 1, 3}), "sync flag");
        end
    endtask : code_sweep

    // Counts ticks over 1000 cycles against the rate formula, one tick of slack.
    task automatic rate_chk(input logic [3:0] e, input logic [7:0] m);
        longint ex;
        int n;
        host_model_i.write_reg(6'h10, {4'h8, e});
        host_model_i.write_reg(6'h11, m);
        ex = (longint'(1000) * ((256 + m) << e)) >> 28;
        n = 0;
        repeat (1000) begin
            @(negedge clk);
            if (symbol_tick === 1'b1) n++;
        end
        chk(n >= ex - 1 && n <= ex + 1, "symbol rate");
    endtask : rate_chk

    // Follows eight ticks; with coding on, each second chip inverts the first.
    task automatic chip_chk(input logic manch);
        logic bit_v, first;
        int w;
        host_model_i.write_reg(6'h12, {4'h0, manch, 3'h1});
        #1;
        chk(modem_cfg.manchester_en === manch, "coding flag");
        for (int k = 0; k < 8; k++) begin
            w = 0;
            do begin
                @(negedge clk);
                w++;
            end while (symbol_tick !== 1'b1 && w < 100);
            chk(tx_bit_take === (!manch || k % 2 == 0), "bit take");
            if (tx_bit_take === 1'b1) bit_v = tx_data_in;
            @(posedge clk);
            #1;
            if (!manch || k % 2 == 0) chk(tx_chip_out === bit_v, "data chip");
            else chk(tx_chip_out === ~first, "inverted chip");
            first = tx_chip_out;
        end
    endtask : chip_chk

    // The timeout ceiling covers all scenarios with ample margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reset_and_rw();
        code_sweep();
        rate_chk(4'hf, 8'hff);
        rate_chk(4'he, 8'h00);
        chip_chk(1'b0);
        chip_chk(1'b1);
        print_verdict();
    end
endmodule : modem_rate_format_config_test
